// *** hw/rev6_opcode_decoder.v ***
// Decode-stage opcode decoder for the revised integer instruction set
`include "opcode_decoder_map.vh"

module rev6_opcode_decoder (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Instruction from fetch
  input  wire        instr_valid,
  input  wire [31:0] instr,
  // Combinational decode
  output reg  [5:0]  dec_op,
  output reg         dec_trap,
  // Registered decode to the pipeline
  output reg         out_valid,
  output reg  [5:0]  op,
  output reg         reserved_instruction_trap,
  output reg         writes_dest,
  output reg  [4:0]  dest_reg,
  output reg  [4:0]  imm_width
);

  ////////////////////////////////////////////////////////////////////////////
  // Fields
  wire [5:0] primary        = instr[`PRIMARY_HI:`PRIMARY_LO];
  wire [4:0] source_a_field = instr[`SOURCE_A_HI:`SOURCE_A_LO];
  wire [4:0] source_b_field = instr[`SOURCE_B_HI:`SOURCE_B_LO];
  wire [4:0] dest_field     = instr[`DEST_HI:`DEST_LO];

  wire       a_zero = (source_a_field == `ZERO_REG);
  wire       b_zero = (source_b_field == `ZERO_REG);
  wire       a_eq_b = (source_a_field == source_b_field);

  ////////////////////////////////////////////////////////////////////////////
  // Family decoders
  wire       md_hit;
  wire       md_trap;
  wire [5:0] md_op;
  wire       pc_hit;
  wire       pc_trap;
  wire [5:0] pc_op;
  wire [4:0] pc_imm_width;

  muldiv_decoder u_muldiv (
    .instr (instr),
    .hit   (md_hit),
    .trap  (md_trap),
    .op    (md_op)
  );

  pcrel_decoder u_pcrel (
    .instr     (instr),
    .hit       (pc_hit),
    .trap      (pc_trap),
    .op        (pc_op),
    .imm_width (pc_imm_width)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Combined decode
  reg       next_writes;
  reg [4:0] next_dest;
  reg [4:0] next_imm;

  always @* begin
    dec_op      = `OP_OTHER;
    dec_trap    = 1'b0;
    next_writes = 1'b0;
    next_dest   = 5'h00;
    next_imm    = 5'h00;
    if (md_hit) begin
      dec_op      = md_op;
      dec_trap    = md_trap;
      next_writes = ~md_trap;
      next_dest   = dest_field;
    end else if (pc_hit) begin
      dec_op      = pc_op;
      dec_trap    = pc_trap;
      next_writes = ~pc_trap;
      next_dest   = source_a_field;
      next_imm    = pc_imm_width;
    end else begin
      case (primary)
        `PRI_BRANCH_GE: begin
          if (b_zero) begin
            dec_trap = 1'b1;
          end else if (a_zero) begin
            dec_op = `OP_BRANCH_LE_ZERO_COMPACT;
          end else if (a_eq_b) begin
            dec_op = `OP_BRANCH_GE_ZERO_COMPACT;
          end else begin
            dec_op = `OP_BRANCH_GE_COMPACT;
          end
        end
        `PRI_GT_ZERO_LIKE: begin
          if (b_zero) begin
            dec_trap = 1'b1;
          end else begin
            dec_op = `OP_COMPACT_OTHER;
          end
        end
        `PRI_LE_ZERO: begin
          if (b_zero) begin
            dec_op = `OP_BRANCH_LE_ZERO;
          end else begin
            dec_op = `OP_COMPACT_OTHER;
          end
        end
        `PRI_GT_ZERO: begin
          if (b_zero) begin
            dec_op = `OP_BRANCH_GT_ZERO;
          end else begin
            dec_op = `OP_COMPACT_OTHER;
          end
        end
        `PRI_ADD_IMM_WORD, `PRI_ADD_IMM_DWORD,
        `PRI_OLD_CP2_WLD, `PRI_OLD_CP2_WST,
        `PRI_OLD_CP2_DLD, `PRI_OLD_CP2_DST: begin
          dec_op = `OP_REUSED_SLOT;
        end
        `PRI_COP2: begin
          case (source_a_field)
            `COP2_WORD_LOAD:   dec_op = `OP_COP2_WORD_LOAD;
            `COP2_WORD_STORE:  dec_op = `OP_COP2_WORD_STORE;
            `COP2_DWORD_LOAD:  dec_op = `OP_COP2_DWORD_LOAD;
            `COP2_DWORD_STORE: dec_op = `OP_COP2_DWORD_STORE;
            default:           dec_op = `OP_OTHER;
          endcase
        end
        default: begin
          dec_op = `OP_OTHER;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode-stage output register
  always @(posedge clock) begin
    if (rst) begin
      out_valid                 <= 1'b0;
      op                        <= `OP_OTHER;
      reserved_instruction_trap <= 1'b0;
      writes_dest               <= 1'b0;
      dest_reg                  <= 5'h00;
      imm_width                 <= 5'h00;
    end else begin
      out_valid                 <= instr_valid;
      op                        <= dec_op;
      reserved_instruction_trap <= instr_valid & dec_trap;
      writes_dest               <= instr_valid & next_writes;
      dest_reg                  <= next_dest;
      imm_width                 <= next_imm;
    end
  end

endmodule // rev6_opcode_decoder

// *** hw/opcode_decoder_map.vh ***
// Field positions, opcode values and operation selector codes
`ifndef OPCODE_DECODER_MAP_VH
`define OPCODE_DECODER_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Instruction fields
`define PRIMARY_HI        31
`define PRIMARY_LO        26
`define SOURCE_A_HI       25
`define SOURCE_A_LO       21
`define SOURCE_B_HI       20
`define SOURCE_B_LO       16
`define DEST_HI           15
`define DEST_LO           11
`define SUBOP_HI          10
`define SUBOP_LO          6
`define FUNC_HI           5
`define FUNC_LO           0

////////////////////////////////////////////////////////////////////////////////
// Primary opcodes
`define PRI_SPECIAL       6'h00
`define PRI_PCREL         6'h3B
`define PRI_BRANCH_GE     6'h16
`define PRI_LE_ZERO       6'h06
`define PRI_GT_ZERO       6'h07
`define PRI_GT_ZERO_LIKE  6'h17
`define PRI_ADD_IMM_WORD  6'h08
`define PRI_ADD_IMM_DWORD 6'h18
`define PRI_COP2          6'h12
`define PRI_OLD_CP2_WLD   6'h32
`define PRI_OLD_CP2_WST   6'h3A
`define PRI_OLD_CP2_DLD   6'h36
`define PRI_OLD_CP2_DST   6'h3E

////////////////////////////////////////////////////////////////////////////////
// Sub-fields
`define FUNC_MULDIV_TOP   3'h3
`define SUBOP_LOW_FORM    5'h02
`define SUBOP_HIGH_FORM   5'h03
`define ZERO_REG          5'h00
`define COP2_WORD_LOAD    5'h0A
`define COP2_WORD_STORE   5'h0B
`define COP2_DWORD_LOAD   5'h0E
`define COP2_DWORD_STORE  5'h0F

////////////////////////////////////////////////////////////////////////////////
// Immediate widths of the PC-relative family
`define IMM_W19           5'h13
`define IMM_W18           5'h12
`define IMM_W17           5'h11
`define IMM_W16           5'h10

////////////////////////////////////////////////////////////////////////////////
// Operation selector codes
`define OP_OTHER                        6'h00
`define OP_PRODUCT_LOW_WORD             6'h01
`define OP_PRODUCT_HIGH_WORD            6'h02
`define OP_UNSIGNED_PRODUCT_LOW         6'h03
`define OP_UNSIGNED_PRODUCT_HIGH        6'h04
`define OP_SIGNED_QUOTIENT              6'h05
`define OP_SIGNED_REMAINDER             6'h06
`define OP_UNSIGNED_QUOTIENT            6'h07
`define OP_UNSIGNED_REMAINDER           6'h08
`define OP_DWORD_PRODUCT_LOW            6'h09
`define OP_DWORD_PRODUCT_HIGH           6'h0A
`define OP_DWORD_UNSIGNED_PRODUCT_LOW   6'h0B
`define OP_DWORD_UNSIGNED_PRODUCT_HIGH  6'h0C
`define OP_DWORD_SIGNED_QUOTIENT        6'h0D
`define OP_DWORD_SIGNED_REMAINDER       6'h0E
`define OP_DWORD_UNSIGNED_QUOTIENT      6'h0F
`define OP_DWORD_UNSIGNED_REMAINDER     6'h10
`define OP_PC_PLUS_IMMEDIATE            6'h11
`define OP_PC_RELATIVE_WORD_LOAD        6'h12
`define OP_PC_RELATIVE_WORD_LOAD_ZX     6'h13
`define OP_PC_RELATIVE_DWORD_LOAD       6'h14
`define OP_PC_PLUS_UPPER_IMMEDIATE      6'h15
`define OP_ALIGNED_PC_PLUS_UPPER_IMM    6'h16
`define OP_BRANCH_GE_COMPACT            6'h17
`define OP_BRANCH_GE_ZERO_COMPACT       6'h18
`define OP_BRANCH_LE_ZERO_COMPACT       6'h19
`define OP_BRANCH_LE_ZERO               6'h1A
`define OP_BRANCH_GT_ZERO               6'h1B
`define OP_COMPACT_OTHER                6'h1C
`define OP_REUSED_SLOT                  6'h1D
`define OP_COP2_WORD_LOAD               6'h1E
`define OP_COP2_WORD_STORE              6'h1F
`define OP_COP2_DWORD_LOAD              6'h20
`define OP_COP2_DWORD_STORE             6'h21

`endif

// *** hw/muldiv_decoder.v ***
// Multiply and divide family decode
`include "opcode_decoder_map.vh"

module muldiv_decoder (
  // Instruction
  input  wire [31:0] instr,
  // Result
  output reg         hit,
  output reg         trap,
  output reg  [5:0]  op
);

  wire [2:0] func_top = instr[`FUNC_HI:`FUNC_HI-2];
  wire [2:0] func_low = instr[`FUNC_LO+2:`FUNC_LO];
  wire [4:0] subop    = instr[`SUBOP_HI:`SUBOP_LO];

  always @* begin
    hit  = (instr[`PRIMARY_HI:`PRIMARY_LO] == `PRI_SPECIAL) &&
           (func_top == `FUNC_MULDIV_TOP);
    trap = 1'b0;
    op   = `OP_OTHER;
    if (hit) begin
      if (subop != `SUBOP_LOW_FORM && subop != `SUBOP_HIGH_FORM) begin
        trap = 1'b1;
      end else begin
        case ({func_low, subop[0]})
          4'h0: op = `OP_PRODUCT_LOW_WORD;
          4'h1: op = `OP_PRODUCT_HIGH_WORD;
          4'h2: op = `OP_UNSIGNED_PRODUCT_LOW;
          4'h3: op = `OP_UNSIGNED_PRODUCT_HIGH;
          4'h4: op = `OP_SIGNED_QUOTIENT;
          4'h5: op = `OP_SIGNED_REMAINDER;
          4'h6: op = `OP_UNSIGNED_QUOTIENT;
          4'h7: op = `OP_UNSIGNED_REMAINDER;
          4'h8: op = `OP_DWORD_PRODUCT_LOW;
          4'h9: op = `OP_DWORD_PRODUCT_HIGH;
          4'hA: op = `OP_DWORD_UNSIGNED_PRODUCT_LOW;
          4'hB: op = `OP_DWORD_UNSIGNED_PRODUCT_HIGH;
          4'hC: op = `OP_DWORD_SIGNED_QUOTIENT;
          4'hD: op = `OP_DWORD_SIGNED_REMAINDER;
          4'hE: op = `OP_DWORD_UNSIGNED_QUOTIENT;
          4'hF: op = `OP_DWORD_UNSIGNED_REMAINDER;
          default: op = `OP_OTHER;
        endcase
      end
    end
  end

endmodule // muldiv_decoder

// *** hw/pcrel_decoder.v ***
// PC-relative family prefix decode
`include "opcode_decoder_map.vh"

module pcrel_decoder (
  // Instruction
  input  wire [31:0] instr,
  // Result
  output reg         hit,
  output reg         trap,
  output reg  [5:0]  op,
  output reg  [4:0]  imm_width
);

  wire [4:0] prefix = instr[`SOURCE_B_HI:`SOURCE_B_LO];

  always @* begin
    hit       = (instr[`PRIMARY_HI:`PRIMARY_LO] == `PRI_PCREL);
    trap      = 1'b0;
    op        = `OP_OTHER;
    imm_width = 5'h00;
    if (hit) begin
      if (prefix[4:3] == 2'h0) begin
        op        = `OP_PC_PLUS_IMMEDIATE;
        imm_width = `IMM_W19;
      end else if (prefix[4:3] == 2'h1) begin
        op        = `OP_PC_RELATIVE_WORD_LOAD;
        imm_width = `IMM_W19;
      end else if (prefix[4:3] == 2'h2) begin
        op        = `OP_PC_RELATIVE_WORD_LOAD_ZX;
        imm_width = `IMM_W19;
      end else if (prefix[2] == 1'b0) begin
        op        = `OP_PC_RELATIVE_DWORD_LOAD;
        imm_width = `IMM_W18;
      end else if (prefix[1] == 1'b0) begin
        trap      = 1'b1;
        imm_width = `IMM_W17;
      end else if (prefix[0] == 1'b0) begin
        op        = `OP_PC_PLUS_UPPER_IMMEDIATE;
        imm_width = `IMM_W16;
      end else begin
        op        = `OP_ALIGNED_PC_PLUS_UPPER_IMM;
        imm_width = `IMM_W16;
      end
    end
  end

endmodule // pcrel_decoder

// *** sim/decoder_chk.sv ***
// Port-level assertions for the opcode decoder
`include "opcode_decoder_map.vh"
module decoder_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Fetch side
  input wire logic        instr_valid,
  input wire logic [31:0] instr,
  // Decode outputs
  input wire logic [5:0]  dec_op,
  input wire logic        dec_trap,
  input wire logic        out_valid,
  input wire logic [5:0]  op,
  input wire logic        reserved_instruction_trap,
  input wire logic        writes_dest,
  input wire logic [4:0]  dest_reg,
  input wire logic [4:0]  imm_width
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [5:0] pri = instr[31:26];
  wire logic [4:0] sa  = instr[25:21];
  wire logic [4:0] sb  = instr[20:16];
  wire logic [4:0] sub = instr[10:6];
  wire logic [4:0] rd  = instr[15:11];
  wire logic       md  = pri == 6'h00 && instr[5:3] == 3'h3;
  wire logic       pc  = pri == 6'h3B;
  wire logic       br  = pri == 6'h16;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  a_muldiv_old_trap: assert property (md && sub[4:1] != 4'h1 |-> dec_trap)
    else $error("bad sub-op not trapped");
  a_muldiv_select: assert property (md && sub[4:1] == 4'h1 |->
    !dec_trap && dec_op == {instr[2:0], sub[0]} + 6'h01) else $error("muldiv selector wrong");
  a_divide_dest: assert property (instr_valid && md && sub == 5'h02 && instr[1] |=>
    writes_dest && dest_reg == $past(rd)) else $error("quotient destination wrong");
  a_pcrel_reserved: assert property (pc && sb[4:1] == 4'hE |-> dec_trap)
    else $error("reserved prefix not trapped");
  a_pcrel_width: assert property (instr_valid && pc && sb[4:3] != 2'h3 |=>
    imm_width == 5'h13 && writes_dest) else $error("wide immediate wrong");
  a_ge_compact: assert property (br && sa != 5'h00 && sb != 5'h00 && sa != sb |->
    dec_op == `OP_BRANCH_GE_COMPACT) else $error("register compare branch wrong");
  a_ge_zero: assert property (br && sa == sb && sb != 5'h00 |->
    dec_op == `OP_BRANCH_GE_ZERO_COMPACT) else $error("equal field branch wrong");
  a_le_zero: assert property (br && sa == 5'h00 && sb != 5'h00 |->
    dec_op == `OP_BRANCH_LE_ZERO_COMPACT) else $error("zero first field branch wrong");
  a_likely_trap: assert property ((br || pri == 6'h17) && sb == 5'h00 |-> dec_trap)
    else $error("likely form not trapped");
  a_legacy_branch: assert property ((pri == 6'h06 || pri == 6'h07) && sb == 5'h00 |->
    dec_op == {5'h0D, pri[0]} && !dec_trap) else $error("legacy branch wrong");
  a_reused_slot: assert property (pri inside {6'h08, 6'h18, 6'h32, 6'h3A, 6'h36, 6'h3E}
    |-> dec_op == `OP_REUSED_SLOT && !dec_trap) else $error("reused slot wrong");
  a_trap_stage: assert property (!$past(rst) |-> out_valid == $past(instr_valid) &&
    reserved_instruction_trap == ($past(dec_trap) && $past(instr_valid)))
    else $error("registered trap wrong");
  ////////////////////////////////////////////////////////////////////////////
  c_high_form: cover property (md && sub == 5'h03);
  c_equal_fields: cover property (br && sa == sb && sb != 5'h00);
  c_pcrel_trap: cover property (pc && sb[4:1] == 4'hE && instr_valid);
endmodule // decoder_chk
bind rev6_opcode_decoder decoder_chk u_chk (.clock, .rst, .instr_valid, .instr, .dec_op,
  .dec_trap, .out_valid, .op, .reserved_instruction_trap, .writes_dest, .dest_reg, .imm_width);

// *** sim/fetch_model.sv ***
// Fetch stage model presenting instruction words
module fetch_model (
  // Clock
  input wire logic   clock,
  // Fetch outputs
  output logic        instr_valid,
  output logic [31:0] instr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    instr_valid = 1'b0;
    instr       = 32'h0000_0000;
  end
  // One word per falling edge; idle slots show a changing pattern
  task automatic send(input logic [31:0] w, input logic v);
    @(negedge clock);
    instr_valid <= v;
    instr       <= v ? w : ~instr;
  endtask
endmodule // fetch_model

// *** sim/rev6_opcode_decoder_tb.sv ***
// Self-checking bench for the opcode decoder
`include "opcode_decoder_map.vh"
module rev6_opcode_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        instr_valid;
  logic [31:0] instr;
  logic [5:0]  dec_op;
  logic        dec_trap;
  logic        out_valid;
  logic [5:0]  op;
  logic        reserved_instruction_trap;
  logic        writes_dest;
  logic [4:0]  dest_reg;
  logic [4:0]  imm_width;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  logic [31:0] r;
  int          mismatches = 0;
  int          check_count = 0;
  int          seed = 32'h5A3F869D;
  logic [4:0]  subs[5] = '{5'h00, 5'h02, 5'h03, 5'h01, 5'h12};
  logic [4:0]  pfx[8] = '{5'h00, 5'h0B, 5'h15, 5'h19, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
  logic [9:0]  ab[6] = '{10'h065, 10'h0E7, 10'h009, 10'h080, 10'h000, 10'h3FF};
  logic [5:0]  pris[10] = '{6'h16, 6'h17, 6'h06, 6'h07, 6'h08, 6'h18, 6'h32, 6'h3A, 6'h36, 6'h3E};
  always #2.5 clock = ~clock;
  rev6_opcode_decoder dut (.clock, .rst, .instr_valid, .instr, .dec_op, .dec_trap, .out_valid,
    .op, .reserved_instruction_trap, .writes_dest, .dest_reg, .imm_width);
  fetch_model u_fetch (.clock, .instr_valid, .instr);
  ////////////////////////////////////////////////////////////////////////////
  // Expected {op, trap, writes, dest, width}
  function automatic logic [17:0] model(input logic [31:0] w);
    logic [5:0] o;
    logic       t;
    logic       d;
    logic [4:0] rg;
    logic [4:0] iw;
    logic [4:0] a;
    logic [4:0] b;
    logic [4:0] s;
    a = w[25:21];
    b = w[20:16];
    s = w[10:6];
    {o, t, d, rg, iw} = 18'h00000;
    case (w[31:26])
      6'h00: if (w[5:3] == 3'h3) begin
        o  = {w[2:0], s[0]} + 6'h01;
        d  = s[4:1] == 4'h1;
        t  = !d;
        rg = w[15:11];
      end
      6'h3B: begin
        d  = 1'b1;
        rg = a;
        o  = `OP_PC_PLUS_UPPER_IMMEDIATE + {5'h00, b[0]};
        iw = 5'h10;
        if (b[4:3] != 2'h3) begin
          o  = `OP_PC_PLUS_IMMEDIATE + {4'h0, b[4:3]};
          iw = 5'h13;
        end else if (!b[2]) begin
          o  = `OP_PC_RELATIVE_DWORD_LOAD;
          iw = 5'h12;
        end else if (!b[1]) begin
          t  = 1'b1;
          d  = 1'b0;
          iw = 5'h11;
        end
      end
      6'h16: if (b == 5'h00) t = 1'b1;
        else if (a == 5'h00) o = `OP_BRANCH_LE_ZERO_COMPACT;
        else if (a == b) o = `OP_BRANCH_GE_ZERO_COMPACT;
        else o = `OP_BRANCH_GE_COMPACT;
      6'h17: if (b == 5'h00) t = 1'b1;
        else o = `OP_COMPACT_OTHER;
      6'h06, 6'h07: o = (b == 5'h00) ? {5'h0D, w[26]} : `OP_COMPACT_OTHER;
      6'h08, 6'h18, 6'h32, 6'h3A, 6'h36, 6'h3E: o = `OP_REUSED_SLOT;
      6'h12: if (a[4:3] == 2'h1 && a[1]) o = `OP_COP2_WORD_LOAD + {4'h0, a[2], a[0]};
      default: ;
    endcase
    return {o, t, d, rg, iw};
  endfunction
  task automatic cmp(input string n, input logic [5:0] x, input logic [5:0] g);
    check_count++;
    if (g !== x) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  // Expectation noted at the falling edge that drives the word, before it reaches the pins, so reset seen at that edge decides
  task automatic put(input logic [31:0] w);
    u_fetch.send(w, 1'b1);
    if (rst === 1'b0) exp_q.push_back(model(w));
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Result monitor
  always @(posedge clock) begin
    #1;
    if (out_valid === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 18'h3FFFF;
      cmp("trap", {5'h00, e[11]}, {5'h00, reserved_instruction_trap});
      cmp("writes", {5'h00, e[10]}, {5'h00, writes_dest});
      if (!e[11]) cmp("op", e[17:12], op);
      if (e[10]) cmp("dest", {1'b0, e[9:5]}, {1'b0, dest_reg});
      cmp("width", {1'b0, e[4:0]}, {1'b0, imm_width});
    end
  end
  initial begin
    #20000;
    mismatches++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clock);
    @(negedge clock);
    rst <= 1'b0;
    for (int f = 0; f < 8; f++)
      foreach (subs[i]) put({6'h00, 15'h24EC, subs[i], 3'h3, f[2:0]});
    $display("done: muldiv grid");
    foreach (pfx[i]) begin
      r = $random(seed);
      put({6'h3B, r[25:21], pfx[i], r[15:0]});
    end
    $display("done: pc-relative prefixes");
    foreach (pris[p])
      foreach (ab[i]) begin
        r = $random(seed);
        put({pris[p], ab[i], r[15:0]});
      end
    for (int a = 8; a < 16; a++) put({6'h12, a[4:0], 21'h0ABCD});
    $display("done: branch and reused slots");
    repeat (300) begin
      r = $random(seed);
      if (r[1]) r[31:26] = 6'h00;
      if (r[2]) r[5:3] = 3'h3;
      if (r[0]) put(r);
      else u_fetch.send(r, 1'b0);
    end
    $display("done: random stream");
    u_fetch.send(32'h0000_0000, 1'b0);
    @(negedge clock);
    rst <= 1'b1;
    put(32'h0000_0098);
    put(32'hEC7C_0001);
    @(posedge clock);
    #1;
    cmp("reset valid", 6'h00, {5'h00, out_valid});
    u_fetch.send(32'h0000_0000, 1'b0);
    rst <= 1'b0;
    put(32'h0000_30DA);
    put(32'h5842_0010);
    repeat (4) u_fetch.send(32'h0000_0000, 1'b0);
    cmp("pending", 6'h00, 6'(exp_q.size()));
    $display("done: reset and drain");
    test_done();
  end
endmodule // rev6_opcode_decoder_tb
